// File: rtl/ldsg_gpio_ports.sv
// Ports C to F with LCD pin sharing and an AXI4-Lite register file.
// Assumes pin inputs are synchronous to core_clk; pads resolve drive.
//
// Functional notes
// - Third port has six bits; bits 7 and 6 read zero.
// - Third-port bit 0 is GPIO or timer oscillator out / timer clock in.
// - Third-port bit 1 is GPIO or timer oscillator in.
// - Third-port bit 2 is GPIO or capture/compare/PWM pin.
// - Third-port bit 3 is GPIO or serial port clock.
// - Third-port bit 4 is GPIO or serial data in / I2C data.
// - Third-port bit 5 is GPIO or serial data out.
// - Fourth port is eight bits; bits 0-4 are GPIO or LCD segments.
// - Fourth-port bits 5-7 are input, segment or common only; never driven.
// - Fourth direction register steers only bits 0-4 in digital use.
// - Every LCD-shared pin starts as LCD segment driver after reset.
// - A pin is digital only while its segment-select bit is zero.
// - A set segment-select bit overrides the direction bits.
// - Fifth port is input only; each pin shares an LCD segment.
// - Sixth port is input only; pins share segments 12 to 19.
// - Clearing groups 16 and 12 makes all sixth-port pins digital.
// - Clearing 27, 5, 9 makes fifth port and seventh-port bit 7 digital.
// - Segment-select register is eight bits, resets to all ones.
// - Direction bit set means high impedance; clear drives the latch.
// - An enabled peripheral overrides a third-port direction bit.
// - Data register reads return pin levels, not the latch.
// - Third- and fourth-port data register writes store into the output latch.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module ldsg_gpio_ports #(
  parameter int AW = ldsg_pkg::ADDR_W
) (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  input  wire logic                        ce,
  input  wire logic [AW-1:0]               s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [ldsg_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [AW-1:0]               s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [ldsg_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [ldsg_pkg::C_W-1:0]    portCIn,
  output logic [ldsg_pkg::C_W-1:0]         portCOut,
  output logic [ldsg_pkg::C_W-1:0]         portCOe,
  input  wire logic [ldsg_pkg::C_W-1:0]    periphEnC,
  input  wire logic [ldsg_pkg::C_W-1:0]    periphOeC,
  input  wire logic [ldsg_pkg::C_W-1:0]    periphOutC,
  input  wire logic [ldsg_pkg::PORT_W-1:0] portDIn,
  output logic [ldsg_pkg::D_IO_W-1:0]      portDOut,
  output logic [ldsg_pkg::D_IO_W-1:0]      portDOe,
  input  wire logic [ldsg_pkg::PORT_W-1:0] portEIn,
  input  wire logic [ldsg_pkg::PORT_W-1:0] portFIn,
  output logic [ldsg_pkg::PORT_W-1:0]      lcdOwnD,
  output logic [ldsg_pkg::PORT_W-1:0]      lcdOwnE,
  output logic [ldsg_pkg::PORT_W-1:0]      lcdOwnF,
  output logic                             lcdOwnG7
);
  import ldsg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [C_W-1:0]    third_port_data;
  logic [C_W-1:0]    third_port_direction;
  logic [D_IO_W-1:0] fourth_port_data;
  logic [PORT_W-1:0] fourth_port_direction;
  logic [PORT_W-1:0] fifth_port_direction;
  logic [PORT_W-1:0] sixth_port_direction;
  logic [PORT_W-1:0] segment_pin_select;

  logic              wrEn;
  logic [AW-1:0]     wrAddr;
  logic [PORT_W-1:0] wrData;
  logic              wrLane0;
  logic              wrHit;
  logic              rdHit;
  logic [PORT_W-1:0] rdValue;
  logic [IDX_W-1:0]  wrIdx;
  logic [IDX_W-1:0]  rdIdx;
  logic              wrGo;

  ////////////////////////////////////////////////////////////////////////
  // Address decode shared by the write and read paths
  function automatic logic [IDX_W-1:0] regIndex(input logic [AW-1:0] a);
    return a[IDX_W+1:2];
  endfunction

  function automatic logic isMapped(input logic [AW-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = regIndex(a);
    if (a[1:0] != 2'h0 || a[AW-1:IDX_W+2] != '0) begin
      return 1'b0;
    end
    case (idx)
      IDX_C_DATA, IDX_D_DATA, IDX_E_DATA,
      IDX_C_DIR, IDX_D_DIR, IDX_E_DIR,
      IDX_F_DATA, IDX_SEG_SEL, IDX_F_DIR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  assign wrIdx = regIndex(wrAddr);
  assign rdIdx = regIndex(s_axi_araddr);
  assign wrHit = isMapped(wrAddr);
  assign rdHit = isMapped(s_axi_araddr);
  assign wrGo  = wrEn & wrHit & wrLane0;

  ldsg_axil_slave #(
    .AW (AW)
  ) u_bus (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .awaddr   (s_axi_awaddr),
    .awvalid  (s_axi_awvalid),
    .awready  (s_axi_awready),
    .wdata    (s_axi_wdata),
    .wstrb    (s_axi_wstrb),
    .wvalid   (s_axi_wvalid),
    .wready   (s_axi_wready),
    .bresp    (s_axi_bresp),
    .bvalid   (s_axi_bvalid),
    .bready   (s_axi_bready),
    .arvalid  (s_axi_arvalid),
    .arready  (s_axi_arready),
    .rdata    (s_axi_rdata),
    .rresp    (s_axi_rresp),
    .rvalid   (s_axi_rvalid),
    .rready   (s_axi_rready),
    .wrEn     (wrEn),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .wrLane0  (wrLane0),
    .wrHit    (wrHit),
    .rdHit    (rdHit),
    .rdValue  (rdValue)
  );

  ////////////////////////////////////////////////////////////////////////
  // Segment select: all LCD-shared pins go to the LCD on every reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      segment_pin_select <= RST_SEG_SEL;
    end else if (ce && wrGo && wrIdx == IDX_SEG_SEL) begin
      segment_pin_select <= wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output latches; only implemented bits are stored
  always_ff @(posedge core_clk) begin
    if (srst) begin
      third_port_data  <= RST_LATCH[C_W-1:0];
      fourth_port_data <= RST_LATCH[D_IO_W-1:0];
    end else if (ce && wrGo) begin
      if (wrIdx == IDX_C_DATA) begin
        third_port_data <= wrData[C_W-1:0];
      end
      if (wrIdx == IDX_D_DATA) begin
        fourth_port_data <= wrData[D_IO_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Direction registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      third_port_direction  <= RST_C_DIR;
      fourth_port_direction <= RST_DIR;
      fifth_port_direction  <= RST_DIR;
      sixth_port_direction  <= RST_DIR;
    end else if (ce && wrGo) begin
      case (wrIdx)
        IDX_C_DIR: third_port_direction  <= wrData[C_W-1:0];
        IDX_D_DIR: fourth_port_direction <= wrData;
        IDX_E_DIR: fifth_port_direction  <= wrData;
        IDX_F_DIR: sixth_port_direction  <= wrData;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin ownership by segment group
  assign lcdOwnD[D_IO_W-1:0]      = {D_IO_W{segment_pin_select[SEB_G0]}};
  assign lcdOwnD[PORT_W-1:D_IO_W] = {3{segment_pin_select[SEB_G29]}};
  assign lcdOwnE[3:0]             = {4{segment_pin_select[SEB_G5]}};
  assign lcdOwnE[6:4]             = {3{segment_pin_select[SEB_G9]}};
  assign lcdOwnE[7]               = segment_pin_select[SEB_G27];
  assign lcdOwnF[3:0]             = {4{segment_pin_select[SEB_G12]}};
  assign lcdOwnF[7:4]             = {4{segment_pin_select[SEB_G16]}};
  assign lcdOwnG7                 = segment_pin_select[SEB_G27];

  ////////////////////////////////////////////////////////////////////////
  // Third port: timer, capture/compare/PWM and serial port may take a pin
  ldsg_pin_cell #(
    .W (C_W)
  ) u_cells_c (
    .latch  (third_port_data),
    .dir    (third_port_direction),
    .lcdOwn ('0),
    .altEn  (periphEnC),
    .altOe  (periphOeC),
    .altOut (periphOutC),
    .pinOut (portCOut),
    .pinOe  (portCOe)
  );

  // Fourth port: only bits 0-4 have a driver; the upper pins have none
  ldsg_pin_cell #(
    .W (D_IO_W)
  ) u_cells_d (
    .latch  (fourth_port_data),
    .dir    (fourth_port_direction[D_IO_W-1:0]),
    .lcdOwn (lcdOwnD[D_IO_W-1:0]),
    .altEn  ('0),
    .altOe  ('0),
    .altOut ('0),
    .pinOut (portDOut),
    .pinOe  (portDOe)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read mux: data registers give pin levels, LCD-owned pins read as zero
  always_comb begin
    case (rdIdx)
      IDX_C_DATA:  rdValue = {2'h0, portCIn};
      IDX_D_DATA:  rdValue = portDIn & ~lcdOwnD;
      IDX_E_DATA:  rdValue = portEIn & ~lcdOwnE;
      IDX_F_DATA:  rdValue = portFIn & ~lcdOwnF;
      IDX_C_DIR:   rdValue = {2'h0, third_port_direction};
      IDX_D_DIR:   rdValue = fourth_port_direction;
      IDX_E_DIR:   rdValue = fifth_port_direction;
      IDX_F_DIR:   rdValue = sixth_port_direction;
      IDX_SEG_SEL: rdValue = segment_pin_select;
      default:     rdValue = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence writeThirdData;
    ce && wrGo && wrIdx == IDX_C_DATA;
  endsequence

  sequence readSixthData;
    ce && s_axi_arvalid && s_axi_arready && rdHit && rdIdx == IDX_F_DATA;
  endsequence

  sequence bothTaken;
    ce && wrEn;
  endsequence

  sequence writeSegSel;
    ce && wrGo && wrIdx == IDX_SEG_SEL;
  endsequence

  sequence writeFourthData;
    ce && wrGo && wrIdx == IDX_D_DATA;
  endsequence

  sequence readThirdData;
    ce && s_axi_arvalid && s_axi_arready && rdIdx == IDX_C_DATA;
  endsequence

  seg_reset_ones_a: assert property ($past(srst) |-> segment_pin_select == 8'hFF && lcdOwnD == 8'hFF)
    else $error("segment select not all ones after reset");

  c_latch_write_a: assert property (writeThirdData |=> third_port_data == $past(wrData[C_W-1:0]))
    else $error("third port latch did not take written value");

  f_read_pins_a: assert property (readSixthData |=> s_axi_rvalid
                                  && s_axi_rdata[7:0] == ($past(portFIn) & ~$past(lcdOwnF)))
    else $error("sixth port read does not show pin levels");

  c_upper_zero_a: assert property (ce && s_axi_arvalid && s_axi_arready && rdIdx == IDX_C_DIR
                                   |=> s_axi_rdata[7:6] == 2'h0)
    else $error("third port upper bits read nonzero");

  c_periph_ovr_a: assert property ((periphEnC & (portCOe ^ periphOeC)) == '0)
    else $error("peripheral did not override third port direction");

  d_lcd_block_a: assert property (segment_pin_select[SEB_G0] |-> portDOe == '0)
    else $error("fourth port driven while owned by LCD");

  d_dir_drive_a: assert property (ce && wrGo && wrIdx == IDX_D_DIR && wrData[0] == 1'b0
                                  && !segment_pin_select[SEB_G0] ##1 !(ce && wrGo)
                                  |-> portDOe[0] && portDOut[0] == fourth_port_data[0])
    else $error("cleared direction bit does not drive latch");

  f_group_own_a: assert property (!segment_pin_select[SEB_G12] && !segment_pin_select[SEB_G16]
                                  |-> lcdOwnF == 8'h00)
    else $error("sixth port pins not digital after group clear");

  b_resp_time_a: assert property (bothTaken |=> s_axi_bvalid && $past(wrHit) == (s_axi_bresp == RESP_OKAY))
    else $error("write response late or wrong");

  seg_write_a: assert property (writeSegSel |=> segment_pin_select == $past(wrData))
    else $error("segment select did not take written value");

  d_latch_write_a: assert property (writeFourthData |=> fourth_port_data == $past(wrData[D_IO_W-1:0]))
    else $error("fourth port latch did not take written value");

  c_data_upper_a: assert property (readThirdData |=> s_axi_rdata[7:6] == 2'h0)
    else $error("third port data upper bits read nonzero");

  rst_own_all_a: assert property ($past(srst) |-> lcdOwnE == 8'hFF && lcdOwnF == 8'hFF && lcdOwnG7)
    else $error("shared pins not LCD owned after reset");

  d_upper_own_a: assert property (segment_pin_select[SEB_G29] |-> lcdOwnD[7:5] == 3'h7)
    else $error("fourth port upper pins not LCD owned");

  e_group_own_a: assert property (!segment_pin_select[SEB_G5] && !segment_pin_select[SEB_G9]
                                  && !segment_pin_select[SEB_G27] |-> lcdOwnE == 8'h00 && !lcdOwnG7)
    else $error("fifth port pins not digital after group clear");

  d_dir_scope_a: assert property (!segment_pin_select[SEB_G0]
                                  |-> portDOe == ~fourth_port_direction[D_IO_W-1:0])
    else $error("fourth port drive ignores direction");

  c_gpio_dir_a: assert property ((~periphEnC & (portCOe ^ ~third_port_direction)) == '0)
    else $error("third port drive does not follow direction");

  ro_write_a: assert property (ce && wrGo && (wrIdx == IDX_E_DATA || wrIdx == IDX_F_DATA)
                               |=> $stable(fourth_port_data) && $stable(segment_pin_select))
    else $error("input only data write changed state");

  in_dir_free_a: assert property (ce && wrGo && (wrIdx == IDX_E_DIR || wrIdx == IDX_F_DIR)
                                  |=> $stable(portDOe) && $stable(third_port_direction))
    else $error("input only direction write changed a driver");

  f_low_own_a: assert property (segment_pin_select[SEB_G12] |-> lcdOwnF[3:0] == 4'hF)
    else $error("sixth port low pins not LCD owned");
endmodule

// File: rtl/ldsg_pkg.sv
// Shared constants for the LCD-shared GPIO ports block.
// Assumes a 32-bit AXI4-Lite master and one core clock.
package ldsg_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Bus geometry: byte address is four times the register index
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 9;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int C_W    = 6;
  localparam int D_IO_W = 5;

  ////////////////////////////////////////////////////////////////////////
  // Register indices
  localparam logic [IDX_W-1:0] IDX_C_DATA  = 9'h007;
  localparam logic [IDX_W-1:0] IDX_D_DATA  = 9'h008;
  localparam logic [IDX_W-1:0] IDX_E_DATA  = 9'h009;
  localparam logic [IDX_W-1:0] IDX_C_DIR   = 9'h087;
  localparam logic [IDX_W-1:0] IDX_D_DIR   = 9'h088;
  localparam logic [IDX_W-1:0] IDX_E_DIR   = 9'h089;
  localparam logic [IDX_W-1:0] IDX_F_DATA  = 9'h107;
  localparam logic [IDX_W-1:0] IDX_SEG_SEL = 9'h10D;
  localparam logic [IDX_W-1:0] IDX_F_DIR   = 9'h187;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [C_W-1:0]    RST_C_DIR   = 6'h3F;
  localparam logic [PORT_W-1:0] RST_DIR     = 8'hFF;
  localparam logic [PORT_W-1:0] RST_SEG_SEL = 8'hFF;
  localparam logic [PORT_W-1:0] RST_LATCH   = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Segment-select field positions
  localparam int SEB_G0  = 0;
  localparam int SEB_G5  = 1;
  localparam int SEB_G9  = 2;
  localparam int SEB_G12 = 3;
  localparam int SEB_G16 = 4;
  localparam int SEB_G20 = 5;
  localparam int SEB_G27 = 6;
  localparam int SEB_G29 = 7;

  ////////////////////////////////////////////////////////////////////////
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/ldsg_pin_cell.sv
// Per-pin output steering for a group of shared pins.
// Assumes the caller passes LCD ownership and peripheral overrides per bit.
`timescale 1ns/10ps
module ldsg_pin_cell #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] lcdOwn,
  input  wire logic [W-1:0] altEn,
  input  wire logic [W-1:0] altOe,
  input  wire logic [W-1:0] altOut,
  output logic      [W-1:0] pinOut,
  output logic      [W-1:0] pinOe
);
  import ldsg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // LCD ownership beats everything; a peripheral beats the direction bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign pinOut[i] = altEn[i] ? altOut[i] : latch[i];
    assign pinOe[i]  = ~lcdOwn[i] & (altEn[i] ? altOe[i] : ~dir[i]);
  end
endmodule

// File: rtl/ldsg_axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight.
// Assumes the register file decodes addresses and supplies read data.
`timescale 1ns/10ps
module ldsg_axil_slave #(
  parameter int AW = ldsg_pkg::ADDR_W
) (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  input  wire logic                        ce,
  input  wire logic [AW-1:0]               awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [ldsg_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [ldsg_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  output logic                             wrEn,
  output logic [AW-1:0]                    wrAddr,
  output logic [ldsg_pkg::PORT_W-1:0]      wrData,
  output logic                             wrLane0,
  input  wire logic                        wrHit,
  input  wire logic                        rdHit,
  input  wire logic [ldsg_pkg::PORT_W-1:0] rdValue
);
  import ldsg_pkg::*;

  logic awFull;
  logic wFull;

  assign awready = ce & ~awFull;
  assign wready  = ce & ~wFull;
  assign arready = ce & ~rvalid;
  assign wrEn    = ce & awFull & wFull & ~bvalid;

  ////////////////////////////////////////////////////////////////////////
  // Address and data are held independently until both are present
  always_ff @(posedge core_clk) begin
    if (srst) begin
      awFull <= 1'b0;
      wrAddr <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awFull <= 1'b1;
        wrAddr <= awaddr;
      end else if (wrEn) begin
        awFull <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wFull   <= 1'b0;
      wrData  <= '0;
      wrLane0 <= 1'b0;
    end else if (ce) begin
      if (wvalid && wready) begin
        wFull   <= 1'b1;
        wrData  <= wdata[PORT_W-1:0];
        wrLane0 <= wstrb[0];
      end else if (wrEn) begin
        wFull <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wrEn) begin
        bvalid <= 1'b1;
        bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data is captured at the address handshake
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rdHit ? {{(DATA_W-PORT_W){1'b0}}, rdValue} : '0;
        rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: tb/ldsg_pin_model.sv
// Far-side pads of the third and fourth ports.
// Assumes an undriven pad settles to the external source level.
`timescale 1ns/10ps
module ldsg_pin_model (
  input  wire logic [ldsg_pkg::C_W-1:0]    cOut,
  input  wire logic [ldsg_pkg::C_W-1:0]    cOe,
  input  wire logic [ldsg_pkg::C_W-1:0]    cExt,
  input  wire logic [ldsg_pkg::D_IO_W-1:0] dOut,
  input  wire logic [ldsg_pkg::D_IO_W-1:0] dOe,
  input  wire logic [ldsg_pkg::PORT_W-1:0] dExt,
  output logic      [ldsg_pkg::C_W-1:0]    cIn,
  output logic      [ldsg_pkg::PORT_W-1:0] dIn
);
  import ldsg_pkg::*;
  assign cIn = (cOe & cOut) | (~cOe & cExt);
  assign dIn = {dExt[7:5], (dOe & dOut) | (~dOe & dExt[4:0])};
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the shared GPIO ports block.
// Assumes the pad model above and a 40 MHz core clock.
`timescale 1ns/10ps
module tb_top;
  import ldsg_pkg::*;
  typedef struct {logic [11:0] a; logic wr; logic [7:0] d; logic [7:0] e;} ldsg_row_t;
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic [11:0] awaddr   = '0;
  logic [11:0] araddr   = '0;
  logic [31:0] wdata    = '0;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic        ce       = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, ownG7;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp;
  logic [5:0]  cIn, cOut, cOe;
  logic [5:0]  pEn      = '0;
  logic [5:0]  pOe      = '0;
  logic [5:0]  pOut     = '0;
  logic [7:0]  dIn, ownD, ownE, ownF;
  logic [4:0]  dOut, dOe;
  int          errCount       = 0;
  int          samplesChecked = 0;
  ldsg_row_t   rows [18];

  always #12.5 core_clk = ~core_clk;

  ldsg_gpio_ports u_dut (.core_clk(core_clk), .srst(srst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .portCIn(cIn), .portCOut(cOut), .portCOe(cOe), .periphEnC(pEn), .periphOeC(pOe),
    .periphOutC(pOut), .portDIn(dIn), .portDOut(dOut), .portDOe(dOe), .portEIn(8'hC3),
    .portFIn(8'h96), .lcdOwnD(ownD), .lcdOwnE(ownE), .lcdOwnF(ownF), .lcdOwnG7(ownG7));

  ldsg_pin_model u_pins (.cOut(cOut), .cOe(cOe), .cExt(6'h15), .dOut(dOut), .dOe(dOe),
    .dExt(8'h5A), .cIn(cIn), .dIn(dIn));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] ba(input logic [8:0] i);
    return {1'b0, i, 2'b00};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samplesChecked++;
    if (s !== e) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic axWr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) errCount++;
    @(posedge core_clk);
  endtask

  task automatic axRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) errCount++;
    @(posedge core_clk);
  endtask

  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    reportAndStop();
  end

  initial begin
    logic [31:0] rd;
    logic [1:0]  rs;
    rows = '{'{ba(IDX_C_DIR), 0, 0, 8'h3F}, '{ba(IDX_D_DIR), 0, 0, 8'hFF},
      '{ba(IDX_E_DIR), 0, 0, 8'hFF}, '{ba(IDX_F_DIR), 0, 0, 8'hFF},
      '{ba(IDX_SEG_SEL), 0, 0, 8'hFF}, '{ba(IDX_C_DATA), 0, 0, 8'h15},
      '{ba(IDX_D_DATA), 0, 0, 8'h00}, '{ba(IDX_E_DATA), 0, 0, 8'h00},
      '{ba(IDX_F_DATA), 0, 0, 8'h00}, '{ba(IDX_C_DIR), 1, 8'hFF, 8'h3F},
      '{ba(IDX_D_DIR), 1, 8'h07, 8'h07}, '{ba(IDX_E_DIR), 1, 8'h5A, 8'h5A},
      '{ba(IDX_F_DIR), 1, 8'hA5, 8'hA5}, '{ba(IDX_E_DATA), 1, 8'hFF, 8'h00},
      '{ba(IDX_SEG_SEL), 1, 8'h00, 8'h00}, '{ba(IDX_E_DATA), 0, 0, 8'hC3},
      '{ba(IDX_F_DATA), 0, 0, 8'h96}, '{ba(IDX_D_DATA), 0, 0, 8'h42}};
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk("lcdOwn", {ownD, ownE, ownF, 7'h0, ownG7}, 32'hFFFFFF01);
    chk("driveEn", {cOe, dOe}, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) axWr(rows[i].a, rows[i].d, rs);
      axRd(rows[i].a, rd, rs);
      chk("row", rd, {24'h0, rows[i].e});
    end
    $display("register table done");
    // Third port drive, then peripheral takeover
    axWr(ba(IDX_C_DATA), 8'hFF, rs);
    axWr(ba(IDX_C_DIR), 8'h0F, rs);
    chk("portCOe", cOe, 32'h30);
    chk("portCOut", cOut, 32'h3F);
    axRd(ba(IDX_C_DATA), rd, rs);
    chk("cData", rd, 32'h35);
    pEn <= 6'h3F;
    pOe <= 6'h2F;
    pOut <= 6'h2A;
    @(posedge core_clk);
    chk("periphOe", cOe, 32'h2F);
    chk("periphOut", cOut, 32'h2A);
    axRd(ba(IDX_C_DATA), rd, rs);
    chk("cPeriph", rd, 32'h3A);
    pEn <= 6'h00;
    // Clock enable low stalls the bus; the write lands once it rises
    ce <= 1'b0;
    fork
      begin
        repeat (4) @(posedge core_clk);
        chk("ceStall", {awready, wready, bvalid}, 32'h0);
        ce <= 1'b1;
      end
    join_none
    axWr(ba(IDX_C_DATA), 8'h0A, rs);
    chk("ceWrite", cOut, 32'h0A);
    $display("third port done");
    // Fourth port: segment select overrides direction
    axWr(ba(IDX_SEG_SEL), 8'hFF, rs);
    axWr(ba(IDX_D_DIR), 8'h00, rs);
    axWr(ba(IDX_D_DATA), 8'hFF, rs);
    chk("dOeOwned", {ownD, 3'h0, dOe}, 32'hFF00);
    axWr(ba(IDX_SEG_SEL), 8'hFE, rs);
    chk("dDrive", {ownD, 3'h0, dOe, 3'h0, dOut}, 32'hE01F1F);
    axRd(ba(IDX_D_DATA), rd, rs);
    chk("dLow", rd, 32'h1F);
    axWr(ba(IDX_SEG_SEL), 8'h7E, rs);
    axRd(ba(IDX_D_DATA), rd, rs);
    chk("dHigh", rd, 32'h5F);
    axWr(ba(IDX_D_DIR), 8'h1E, rs);
    axRd(ba(IDX_D_DATA), rd, rs);
    chk("dBit0", {dOe, rd[7:0]}, 32'h15B);
    $display("fourth port done");
    // Segment groups for the fifth and sixth ports
    axWr(ba(IDX_SEG_SEL), 8'hB9, rs);
    chk("ownEG", {ownE, ownF, 7'h0, ownG7}, 32'h00FF00);
    axWr(ba(IDX_SEG_SEL), 8'hE7, rs);
    chk("ownF", {ownE, ownF, 7'h0, ownG7}, 32'hFF0001);
    axRd(ba(IDX_F_DATA), rd, rs);
    chk("fData", rd, 32'h96);
    // Unmapped and misaligned accesses
    axRd(12'h000, rd, rs);
    chk("badRd", {rs, rd[29:0]}, 32'h80000000);
    axWr(12'h436, 8'h00, rs);
    chk("badWr", rs, RESP_SLVERR);
    $display("groups and errors done");
    // Second reset mid-run
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    axRd(ba(IDX_SEG_SEL), rd, rs);
    chk("segReset", {rd[7:0], ownD, 2'h0, cOe}, 32'hFFFF00);
    $display("second reset done");
    reportAndStop();
  end
endmodule
